/* File: dv/dbgcfg_host_model.sv */
// Development system model that drives the serial debug link.
// Assumes the device samples the serial clock with its own faster clock.
`timescale 1ns/1ns
module dbgcfg_host_model (
    // Serial link
    output logic      o_sclk,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    initial begin
        o_sclk = 1'b0;
        o_sdi  = 1'b1;
    end

    // frame of command and data, clock still outside frames
    task automatic xfer(input logic [1:0] cmd, input logic [31:0] wdata, output logic [33:0] resp);
        logic [33:0] f;
        f = {cmd, wdata};
        #13 o_sdi = f[33];
        #160;
        for (int i = 33; i >= 0; i--) begin
            o_sclk = 1'b1;
            #160 o_sclk = 1'b0;
            // Released data line shows the inverse so a stale bit cannot pass
            o_sdi = (i > 0) ? f[(i > 0) ? i - 1 : 0] : ~f[0];
            // out is taken just before the next rise, never at the first
            #150 resp[i] = i_sdo;
            #10;
        end
    endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the debug configuration block.
// Assumes the host model owns the serial link; core events are driven here.
`timescale 1ns/1ns
module tb;
    import dbgcfg_pkg::*;
    logic             i_sys_clk = 1'b0;
    logic             i_rst_b   = 1'b0;
    logic             pin_n = 1'b1, wr_en = 1'b0, trace_to_emulator = 1'b0, ex = 1'b0, idone = 1'b0, hlt = 1'b0, sup = 1'b1;
    logic             rv = 1'b0, rf = 1'b0, ov = 1'b0, ow = 1'b0, bt = 1'b0, bv = 1'b0, so_q = 1'b0;
    logic [1:0]       osz = 2'h0;
    logic [2:0]       irq = 3'h5;
    logic [31:0]      wd = 32'h0, od = 32'h0, ba = 32'h0, v;
    logic             sclk, sdi, sdo, force_emulator_start, hok, herr, no_overlap_exec, shalt;
    logic [2:0]       irq_o;
    logic [33:0]      r;
    dbgcfg_attr_type  attr;
    dbgcfg_debug_data_port_type ddp;
    int               mismatches = 0, num_checks = 0, n, quiet = 0, e, want;

    always #20 i_sys_clk = ~i_sys_clk;

    dbgcfg_host_model host (.o_sclk(sclk), .o_sdi(sdi), .i_sdo(sdo));
    dbgcfg_top dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reset_input_n(pin_n),
        .i_serial_debug_clock(sclk), .i_serial_debug_in(sdi), .o_serial_debug_out(sdo),
        .i_core_wr_en(wr_en), .i_core_wr_data(wd), .i_trace_exc(trace_to_emulator), .i_emu_exit(ex),
        .i_instr_done(idone), .i_halt_exec(hlt), .i_supervisor(sup), .i_core_irq_level(irq),
        .i_ref_valid(rv), .i_ref_fetch(rf), .i_opnd_valid(ov), .i_opnd_write(ow), .i_opnd_size(osz),
        .i_opnd_data(od), .i_br_taken(bt), .i_br_variant(bv), .i_br_addr(ba), .o_emulator_mode(force_emulator_start),
        .o_ref_attr(attr), .o_debug_data_port(ddp), .o_halt_ok(hok), .o_halt_priv_err(herr),
        .o_no_overlap_exec(no_overlap_exec), .o_core_irq_level(irq_o), .o_core_step_halt(shalt));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge i_sys_clk);
    endtask
    task automatic cwr(input logic [31:0] d);
        @(posedge i_sys_clk);
        wr_en <= 1'b1;
        wd <= d;
        @(posedge i_sys_clk);
        wr_en <= 1'b0;
        cyc(2);
    endtask
    task automatic sx(input logic [1:0] c, input logic [31:0] d);
        host.xfer(c, d, r);
        cyc(4);
    endtask
    task automatic srd(input logic [31:0] exp);
        sx(SER_CMD_READ, 32'h0);
        chk({30'h0, r[33:32]}, 32'h0, "lead bits");
        chk(r[31:0], exp, "config read");
    endtask
    // Gathers the byte stream shown after one capture request
    task automatic getb;
        n = 0;
        v = 32'h0;
        repeat (12) begin
            @(posedge i_sys_clk);
            #1;
            if (ddp.valid === 1'b1) begin
                if (n < 4) v[8*n+:8] = ddp.data;
                n++;
            end
        end
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // serial out holds while the serial clock rests low
    always @(posedge i_sys_clk) begin
        quiet <= sclk ? 0 : quiet + 1;
        so_q <= sdo;
        if (i_rst_b && quiet > 4) chk({31'h0, sdo}, {31'h0, so_q}, "serial out moved");
    end

    initial begin
        #400000;
        mismatches++;
        conclude();
    end

    initial begin
        cyc(10);
        i_rst_b <= 1'b1;
        cyc(3);
        srd(32'h0);
        sx(SER_CMD_WRITE, CFG_WMASK);
        cwr(32'h0);
        srd(CFG_WMASK);
        chk({31'h0, no_overlap_exec}, 32'h1, "no overlap");
        chk({29'h0, irq_o}, 32'h0, "irq masked");
        sx(SER_CMD_WRITE, 32'h0);
        cwr(32'h0001_0040);
        srd(32'h0000_0040);
        chk({29'h0, irq_o}, 32'h5, "irq passes");
        tdone("access");
        cwr(32'h0000_C000);
        chk({31'h0, no_overlap_exec}, 32'h0, "overlap allowed");
        @(posedge i_sys_clk) trace_to_emulator <= 1'b1;
        @(posedge i_sys_clk) trace_to_emulator <= 1'b0;
        cyc(2);
        chk({31'h0, force_emulator_start}, 32'h1, "trace entry");
        for (e = 0; e < 4; e++) begin
            if (e == 2) cwr(32'h0000_4000);
            @(posedge i_sys_clk);
            rf <= e[0];
            sup <= 1'b0;
            rv <= 1'b1;
            @(posedge i_sys_clk) rv <= 1'b0;
            cyc(1);
            // User-mode core still gets supervisor spaces while in emulator mode with mapping clear
            v = {27'h0, TT_NORMAL, e[0] ? TM_SUP_FETCH : TM_SUP_DATA};
            if (e < 2) v = {27'h0, TT_EMU, e[0] ? TM_EMU_FETCH : TM_EMU_DATA};
            chk({27'h0, attr}, v, "attr");
        end
        @(posedge i_sys_clk) ex <= 1'b1;
        sup <= 1'b1;
        @(posedge i_sys_clk) ex <= 1'b0;
        cwr(32'h0);
        @(posedge i_sys_clk) trace_to_emulator <= 1'b1;
        @(posedge i_sys_clk) trace_to_emulator <= 1'b0;
        cyc(2);
        chk({31'h0, force_emulator_start}, 32'h0, "trace ignored");
        for (e = 1; e >= 0; e--) begin
            cwr(e[0] ? 32'h0000_2000 : 32'h0);
            pin_n <= 1'b0;
            cyc(4);
            pin_n <= 1'b1;
            cyc(8);
            chk({31'h0, force_emulator_start}, e, "force start");
        end
        tdone("emulator");
        for (e = 0; e < 8; e++) begin
            cwr({19'h0, e[2:1], 11'h0});
            @(posedge i_sys_clk);
            ov <= 1'b1;
            ow <= e[0];
            osz <= 2'((e[2:1] + e[0]) % 3);
            od <= 32'hA1B2_C3D4;
            @(posedge i_sys_clk) ov <= 1'b0;
            getb();
            want = (e[2:1] == 3 || e[2:1] == {~e[0], e[0]}) ? 1 << ((e[2:1] + e[0]) % 3) : 0;
            chk(n, want, "operand bytes");
            chk(v, 32'hA1B2_C3D4 & ~(32'hFFFF_FFFF << (8 * n)), "operand data");
        end
        for (e = 0; e < 5; e++) begin
            cwr({22'h0, 2'(e == 4 ? 3 : e), 8'h0});
            @(posedge i_sys_clk);
            bt <= 1'b1;
            bv <= (e < 4);
            ba <= 32'h8765_4321;
            @(posedge i_sys_clk) bt <= 1'b0;
            getb();
            chk(n, (e > 0 && e < 4) ? e + 1 : 0, "target bytes");
            chk(v, 32'h8765_4321 & ~(32'hFFFF_FFFF << (8 * n)), "target order");
        end
        tdone("capture");
        for (e = 0; e < 4; e++) begin
            cwr({21'h0, e[1], 10'h0});
            @(posedge i_sys_clk);
            sup <= e[0];
            hlt <= 1'b1;
            @(posedge i_sys_clk) hlt <= 1'b0;
            #1;
            chk({hok, herr}, {30'h0, e != 0, e == 0}, "halt privilege");
        end
        cwr(32'h0000_0030);
        chk({29'h0, irq_o}, 32'h0, "irq while stepping");
        for (e = 0; e < 2; e++) begin
            @(posedge i_sys_clk) idone <= 1'b1;
            @(posedge i_sys_clk) idone <= 1'b0;
            cyc(1);
            chk({31'h0, shalt}, 32'h1, "step halt");
            sx(SER_CMD_GO, 32'h0);
            chk({31'h0, shalt}, 32'h0, "step resume");
        end
        cwr(32'h0000_0020);
        chk({29'h0, irq_o}, 32'h5, "irq not stepping");
        tdone("core");
        conclude();
    end
endmodule

/* File: hw/dbgcfg_pkg.sv */
// Shared constants and carriers for the debug configuration block.
// Assumes a 32-bit configuration word and a 34-bit serial frame.
package dbgcfg_pkg;
    // Configuration word field positions
    localparam int          CFG_INHIBIT_BIT = 16;
    localparam int          CFG_MAP_BIT     = 15;
    localparam int          CFG_TRACE_BIT   = 14;
    localparam int          CFG_FORCE_BIT   = 13;
    localparam int          CFG_OPND_LSB    = 11;
    localparam int          CFG_UHALT_BIT   = 10;
    localparam int          CFG_BTB_LSB     = 8;
    localparam int          CFG_NPL_BIT     = 6;
    localparam int          CFG_IPI_BIT     = 5;
    localparam int          CFG_SSM_BIT     = 4;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
    // Writable control bits; status and reserved bits stay zero
    localparam logic [31:0] CFG_WMASK       = 32'h0001_FF70;
    localparam logic [31:0] CFG_INHIBIT_MSK = 32'h0001_0000;
    // Serial frame: two command bits then 32 data bits, MSB first
    localparam int          SER_FRAME_BITS  = 34;
    localparam logic [5:0]  SER_LAST_BIT    = 6'h21;
    localparam logic [1:0]  SER_CMD_READ    = 2'h0;
    localparam logic [1:0]  SER_CMD_WRITE   = 2'h1;
    localparam logic [1:0]  SER_CMD_GO      = 2'h2;
    // Transfer attributes
    localparam logic [1:0]  TT_NORMAL       = 2'h0;
    localparam logic [1:0]  TT_EMU          = 2'h2;
    localparam logic [2:0]  TM_EMU_DATA     = 3'h5;
    localparam logic [2:0]  TM_EMU_FETCH    = 3'h6;
    localparam logic [2:0]  TM_SUP_DATA     = 3'h5;
    localparam logic [2:0]  TM_SUP_FETCH    = 3'h6;
    localparam logic [2:0]  TM_USR_DATA     = 3'h1;
    localparam logic [2:0]  TM_USR_FETCH    = 3'h2;
    // Operand sizes
    localparam logic [1:0]  SIZE_BYTE       = 2'h0;
    localparam logic [1:0]  SIZE_WORD       = 2'h1;
    localparam logic [1:0]  SIZE_LONG       = 2'h2;

    typedef struct packed {
        logic [1:0] transfer_type;
        logic [2:0] transfer_modifier;
    } dbgcfg_attr_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dbgcfg_debug_data_port_type;

    typedef enum logic [0:0] {
        STEP_RUN    = 1'b0,
        STEP_HALTED = 1'b1
    } dbgcfg_step_type;
endpackage

/* File: hw/dbgcfg_top.sv */
// Debug configuration word, emulator-mode controls, debug data capture and serial debug port.
// Assumes core-side inputs are on i_sys_clk; the serial pins and reset pin are asynchronous.
// Summary of operation
// - Inhibit bit blocks core writes; only serial commands change the inhibit bit.
// - Emulator references with mapping set use transfer type 10, modifier 101/110.
// - Emulator references with mapping clear go to supervisor data and fetch spaces.
// - Trace exception enters emulator mode when trace-to-emulator is set.
// - Force-emulator bit sampled only at reset pin negation; selects emulator start.
// - Operand capture select: none, writes, reads, or both.
// - Captured operand bytes match reference size: one, two or four.
// - Halt legal in supervisor only, unless user halt permit set.
// - Branch target byte select: none, two, three or four bytes.
// - Branch target bytes shown least significant first.
// - Only taken variable-addressing branches, returns and vectors capture targets.
// - No-overlap bit forces one instruction at a time.
// - Interrupt levels ignored while stepping with mask bit set.
// - Single step halts after each instruction; go resumes for one more.
// - Serial output changes only on serial clock rise, never between transfers.
// - First serial clock rise starts shifting the response MSB out.
// - Configuration word clears to zero on system reset.
// - Serial side reads and writes the word; core side writes only.
`timescale 1ns/1ns
module dbgcfg_top (
    // Clock and reset
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst_b,
    // Pins
    input  wire logic                     i_reset_input_n,
    input  wire logic                     i_serial_debug_clock,
    input  wire logic                     i_serial_debug_in,
    output logic                          o_serial_debug_out,
    // Core configuration write, supervisor side
    input  wire logic                     i_core_wr_en,
    input  wire logic [31:0]              i_core_wr_data,
    // Core events
    input  wire logic                     i_trace_exc,
    input  wire logic                     i_emu_exit,
    input  wire logic                     i_instr_done,
    input  wire logic                     i_halt_exec,
    input  wire logic                     i_supervisor,
    input  wire logic [2:0]               i_core_irq_level,
    // Core references
    input  wire logic                     i_ref_valid,
    input  wire logic                     i_ref_fetch,
    // Operand and branch capture
    input  wire logic                     i_opnd_valid,
    input  wire logic                     i_opnd_write,
    input  wire logic [1:0]               i_opnd_size,
    input  wire logic [31:0]              i_opnd_data,
    input  wire logic                     i_br_taken,
    input  wire logic                     i_br_variant,
    input  wire logic [31:0]              i_br_addr,
    // Core controls and status
    output logic                          o_emulator_mode,
    output dbgcfg_pkg::dbgcfg_attr_type   o_ref_attr,
    output dbgcfg_pkg::dbgcfg_debug_data_port_type  o_debug_data_port,
    output logic                          o_halt_ok,
    output logic                          o_halt_priv_err,
    output logic                          o_no_overlap_exec,
    output logic [2:0]                    o_core_irq_level,
    output logic                          o_core_step_halt
);
    import dbgcfg_pkg::*;

    logic [1:0]      rst_sync_reg;
    logic            rst_b;
    logic [2:0]      sclk_sync_reg;
    logic [1:0]      sdi_sync_reg;
    logic [2:0]      rin_sync_reg;
    logic            sclk_rise;
    logic            rin_rise;
    logic [5:0]      bit_cnt_reg;
    logic [32:0]     rx_reg;
    logic [33:0]     tx_reg;
    logic [33:0]     frame;
    logic            ser_done;
    logic [31:0]     cfg_reg;
    logic [31:0]     sh_reg;
    logic [2:0]      left_reg;
    dbgcfg_step_type step_reg;

    function automatic logic opnd_hit(input logic [1:0] sel, input logic wr);
        opnd_hit = wr ? sel[0] : sel[1];
    endfunction

    function automatic logic [2:0] size_bytes(input logic [1:0] size);
        case (size)
            SIZE_BYTE: size_bytes = 3'h1;
            SIZE_WORD: size_bytes = 3'h2;
            default:   size_bytes = 3'h4;
        endcase
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_reg[1];

    // Stage 0 of each synchroniser feeds stage 1 only
    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_sync_reg <= 3'h0;
            sdi_sync_reg  <= 2'h0;
            // Reset pin idles high; starting high avoids a false negation edge after reset
            rin_sync_reg  <= 3'h7;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], i_serial_debug_clock};
            sdi_sync_reg  <= {sdi_sync_reg[0], i_serial_debug_in};
            rin_sync_reg  <= {rin_sync_reg[1:0], i_reset_input_n};
        end
    end
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign rin_rise  = rin_sync_reg[1] & ~rin_sync_reg[2];
    assign frame     = {rx_reg, sdi_sync_reg[1]};
    assign ser_done  = sclk_rise && (bit_cnt_reg == SER_LAST_BIT);

    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_reg        <= 6'h00;
            rx_reg             <= 33'h0_0000_0000;
            tx_reg             <= 34'h0_0000_0000;
            o_serial_debug_out <= 1'b0;
        end else if (sclk_rise) begin
            rx_reg      <= frame[32:0];
            bit_cnt_reg <= ser_done ? 6'h00 : bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == 6'h00) begin
                o_serial_debug_out <= 1'b0;
                tx_reg             <= {2'h0, cfg_reg} << 1;
            end else begin
                o_serial_debug_out <= tx_reg[33];
                tx_reg             <= tx_reg << 1;
            end
        end
    end

    // configuration writes; serial wins a same-cycle clash
    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= CFG_RESET;
        end else if (ser_done && frame[33:32] == SER_CMD_WRITE) begin
            cfg_reg <= frame[31:0] & CFG_WMASK;
        end else if (i_core_wr_en && !cfg_reg[CFG_INHIBIT_BIT]) begin
            cfg_reg <= (i_core_wr_data & CFG_WMASK & ~CFG_INHIBIT_MSK) | (cfg_reg & CFG_INHIBIT_MSK);
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_emulator_mode <= 1'b0;
        end else if (rin_rise) begin
            o_emulator_mode <= cfg_reg[CFG_FORCE_BIT];
        end else if (i_trace_exc && cfg_reg[CFG_TRACE_BIT]) begin
            o_emulator_mode <= 1'b1;
        end else if (i_emu_exit) begin
            o_emulator_mode <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_ref_attr <= '0;
        end else if (i_ref_valid) begin
            if (o_emulator_mode && cfg_reg[CFG_MAP_BIT]) begin
                o_ref_attr.transfer_type     <= TT_EMU;
                o_ref_attr.transfer_modifier <= i_ref_fetch ? TM_EMU_FETCH : TM_EMU_DATA;
            end else begin
                o_ref_attr.transfer_type <= TT_NORMAL;
                if (o_emulator_mode || i_supervisor) begin
                    o_ref_attr.transfer_modifier <= i_ref_fetch ? TM_SUP_FETCH : TM_SUP_DATA;
                end else begin
                    o_ref_attr.transfer_modifier <= i_ref_fetch ? TM_USR_FETCH : TM_USR_DATA;
                end
            end
        end
    end

    // capture; one item at a time, new ones dropped while busy
    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_reg            <= 32'h0000_0000;
            left_reg          <= 3'h0;
            o_debug_data_port <= '0;
        end else begin
            o_debug_data_port.valid <= (left_reg != 3'h0);
            o_debug_data_port.data  <= sh_reg[7:0];
            if (left_reg != 3'h0) begin
                sh_reg   <= sh_reg >> 8;
                left_reg <= left_reg - 3'h1;
            end else if (i_br_taken && i_br_variant && cfg_reg[CFG_BTB_LSB+:2] != 2'h0) begin
                sh_reg   <= i_br_addr;
                left_reg <= {1'b0, cfg_reg[CFG_BTB_LSB+:2]} + 3'h1;
            end else if (i_opnd_valid && opnd_hit(cfg_reg[CFG_OPND_LSB+:2], i_opnd_write)) begin
                sh_reg   <= i_opnd_data;
                left_reg <= size_bytes(i_opnd_size);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_halt_ok         <= 1'b0;
            o_halt_priv_err   <= 1'b0;
            o_no_overlap_exec <= 1'b0;
            o_core_irq_level  <= 3'h0;
        end else begin
            o_halt_ok         <= i_halt_exec && (i_supervisor || cfg_reg[CFG_UHALT_BIT]);
            o_halt_priv_err   <= i_halt_exec && !i_supervisor && !cfg_reg[CFG_UHALT_BIT];
            o_no_overlap_exec <= cfg_reg[CFG_NPL_BIT];
            o_core_irq_level  <= (cfg_reg[CFG_IPI_BIT] && cfg_reg[CFG_SSM_BIT]) ? 3'h0 : i_core_irq_level;
        end
    end

    // single step; while halted, a go beats a same-cycle completion
    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            step_reg <= STEP_RUN;
        end else begin
            case (step_reg)
                STEP_RUN:    step_reg <= (cfg_reg[CFG_SSM_BIT] && i_instr_done) ? STEP_HALTED : STEP_RUN;
                STEP_HALTED: begin
                    if (!cfg_reg[CFG_SSM_BIT] || (ser_done && frame[33:32] == SER_CMD_GO)) begin
                        step_reg <= STEP_RUN;
                    end
                end
                default:     step_reg <= STEP_RUN;
            endcase
        end
    end
    assign o_core_step_halt = (step_reg == STEP_HALTED);

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_emu_ref;
        i_ref_valid && o_emulator_mode;
    endsequence
    sequence s_capture_idle;
        left_reg == 3'h0 && !(i_br_taken && i_br_variant);
    endsequence

    a_core_write_block: assert property (
        i_core_wr_en && cfg_reg[CFG_INHIBIT_BIT] && !ser_done |=> $stable(cfg_reg))
        else $error("core write changed protected configuration");
    a_core_keeps_inhibit: assert property (
        i_core_wr_en && !ser_done |=> cfg_reg[CFG_INHIBIT_BIT] == $past(cfg_reg[CFG_INHIBIT_BIT]))
        else $error("core write changed the inhibit bit");
    a_emu_map_attr: assert property (
        s_emu_ref and cfg_reg[CFG_MAP_BIT] |=> o_ref_attr.transfer_type == TT_EMU
        && o_ref_attr.transfer_modifier == ($past(i_ref_fetch) ? TM_EMU_FETCH : TM_EMU_DATA))
        else $error("emulator mapped reference has wrong attributes");
    a_emu_sup_space: assert property (
        s_emu_ref and !cfg_reg[CFG_MAP_BIT] |=> o_ref_attr.transfer_type == TT_NORMAL
        && o_ref_attr.transfer_modifier == ($past(i_ref_fetch) ? TM_SUP_FETCH : TM_SUP_DATA))
        else $error("emulator reference not in supervisor space");
    a_trace_entry: assert property (
        i_trace_exc && cfg_reg[CFG_TRACE_BIT] && !rin_rise |=> o_emulator_mode)
        else $error("trace exception did not enter emulator mode");
    a_force_start: assert property (
        rin_rise |=> o_emulator_mode == $past(cfg_reg[CFG_FORCE_BIT]))
        else $error("reset negation start mode wrong");
    a_capture_none: assert property (
        s_capture_idle and i_opnd_valid and !opnd_hit(cfg_reg[CFG_OPND_LSB+:2], i_opnd_write)
        |=> left_reg == 3'h0)
        else $error("unselected operand captured");
    a_capture_width: assert property (
        s_capture_idle and i_opnd_valid and opnd_hit(cfg_reg[CFG_OPND_LSB+:2], i_opnd_write)
        |=> left_reg == size_bytes($past(i_opnd_size)))
        else $error("operand byte count wrong");
    a_halt_priv: assert property (
        i_halt_exec && !i_supervisor |=> o_halt_ok == $past(cfg_reg[CFG_UHALT_BIT])
        && o_halt_priv_err != o_halt_ok)
        else $error("halt privilege check wrong");
    a_btb_first_lsb: assert property (
        left_reg == 3'h0 && i_br_taken && i_br_variant && cfg_reg[CFG_BTB_LSB+:2] != 2'h0
        |=> left_reg == {1'b0, $past(cfg_reg[CFG_BTB_LSB+:2])} + 3'h1
        ##1 o_debug_data_port.valid && o_debug_data_port.data == $past(i_br_addr[7:0], 2))
        else $error("branch target capture wrong");
    a_btb_variant: assert property (
        left_reg == 3'h0 && i_br_taken && !i_br_variant && !i_opnd_valid |=> left_reg == 3'h0)
        else $error("fixed branch captured");
    a_no_overlap: assert property (
        1'b1 |=> o_no_overlap_exec == $past(cfg_reg[CFG_NPL_BIT]))
        else $error("no overlap control does not follow its bit");
    a_irq_mask: assert property (
        cfg_reg[CFG_IPI_BIT] && cfg_reg[CFG_SSM_BIT] |=> o_core_irq_level == 3'h0)
        else $error("interrupts passed while stepping");
    a_step_halt: assert property (
        step_reg == STEP_RUN && cfg_reg[CFG_SSM_BIT] && i_instr_done
        |=> o_core_step_halt [*1] ##0 !$past(o_core_step_halt))
        else $error("step did not halt");
    a_step_resume: assert property (
        step_reg == STEP_HALTED && ser_done && frame[33:32] == SER_CMD_GO |=> !o_core_step_halt)
        else $error("go did not resume the stepping core");
    a_dso_stable: assert property (
        !sclk_rise |=> $stable(o_serial_debug_out))
        else $error("serial output changed off clock edge");
    a_frame_msb: assert property (
        sclk_rise && bit_cnt_reg == 6'h00 |=> o_serial_debug_out == 1'b0 && tx_reg[32:1] == $past(cfg_reg))
        else $error("frame first bit not the response MSB");
endmodule
